// File: mts_cfg.svh
// Constants for the transmit client stream sink
// Functional notes
// - Data bus is 256 bits (40G) or 512 bits (100G), n 64-bit words.
// - Interface clock is 312.5 MHz (40G) or 390.625 MHz (100G).
// - Word count n is 4 or 8; empty field is log2(8*n) bits.
// - Sink has ready latency zero: beat taken in cycle ready is high.
// - Valid qualifies data, empty, start, end and error.
// - With preamble pass-through the client supplies preamble; MAC adds none.
// - Error asserted in end beat makes the MAC corrupt that packet.
// - In loopback an error-inserted packet returns classified as malformed.
// - All client signals are synchronous to the single TX MAC clock.
// - Corruption is a 66-bit block of eight error control characters.
`ifndef MTS_CFG_SVH
`define MTS_CFG_SVH

// Variant: 40G build
`define MTS_N_WORDS        4
`define MTS_DATA_W         256
`define MTS_EMPTY_W        5
`define MTS_BEAT_BYTES     6'h20
`define MTS_TXMAC_FREQ_KHZ 312500
`define MTS_MIN_FRAME      16'h0009
`define MTS_PREAMBLE_BYTES 16'h0008
`define MTS_CNT_W          32

// Error block pieces
`define MTS_BLK_SYNC       2'h2
`define MTS_BLK_TYPE       8'h1E
`define MTS_CTL_ERR        7'h1E
`define MTS_DATA_ERR       8'hFE

// Register byte offsets
`define MTS_OFF_CTRL       8'h00
`define MTS_OFF_STATUS     8'h04
`define MTS_OFF_PKT_CNT    8'h08
`define MTS_OFF_ERR_CNT    8'h0C
`define MTS_OFF_MAL_CNT    8'h10

// Control bits
`define MTS_CTRL_ENABLE    0
`define MTS_CTRL_PREAMBLE  1
`define MTS_CTRL_LOOPBACK  2
`define MTS_CTRL_RESET     3'h0

// Status bits
`define MTS_ST_LANES       0
`define MTS_ST_IN_PKT      1
`define MTS_ST_GAP_ERR     2
`define MTS_ST_SHORT_ERR   3

`endif

// File: mts_pkg.sv
// Types for the transmit client stream sink
`include "mts_cfg.svh"
package mts_pkg;

  // One client beat
  typedef struct packed {
    logic [`MTS_DATA_W-1:0]  data;
    logic [`MTS_EMPTY_W-1:0] empty;
    logic                    sop;
    logic                    eop;
    logic                    error;
  } mts_beat_type;

  // One beat toward the framing logic
  typedef struct packed {
    logic [`MTS_DATA_W-1:0]  data;
    logic [`MTS_EMPTY_W-1:0] empty;
    logic                    sop;
    logic                    eop;
    logic                    add_preamble;
    logic                    corrupt;
  } mts_link_type;

  // Packet tracking state
  typedef enum logic [0:0] {
    MTS_IDLE,
    MTS_IN_PKT
  } mts_state_type;

endpackage : mts_pkg

// File: mts_tx_sink.sv
// Transmit client stream sink with APB control and status
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "mts_cfg.svh"
module mts_tx_sink (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // Client stream
  input  wire mts_pkg::mts_beat_type tx_beat,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  // Framing side
  input  wire logic                 lanes_stable,
  input  wire logic                 link_ready,
  output mts_pkg::mts_link_type     link_beat,
  output logic                      link_valid,
  output logic [65:0]               error_block_pattern,
  output logic                      lb_malformed
);

  // State
  logic [2:0]                ctrl_reg;
  logic                      gap_err_reg;
  logic                      short_err_reg;
  logic [`MTS_CNT_W-1:0]     pkt_cnt_reg;
  logic [`MTS_CNT_W-1:0]     err_cnt_reg;
  logic [`MTS_CNT_W-1:0]     mal_cnt_reg;
  logic [15:0]               bytes_reg;
  mts_pkg::mts_state_type    state_reg;
  mts_pkg::mts_state_type    state_next;
  logic                      ready_reg;
  mts_pkg::mts_link_type     link_reg;
  logic                      link_valid_reg;
  logic [65:0]               eblock_reg;
  logic                      lb_mal_reg;
  logic                      pready_reg;
  logic [31:0]               prdata_reg;
  logic                      pslverr_reg;

  // Transfer qualification
  wire logic                 accept;
  wire logic                 in_pkt;
  wire logic                 gap_seen;
  wire logic [15:0]          frame_bytes;
  wire logic                 short_seen;
  wire logic                 corrupt;
  wire logic                 ready_next;

  assign accept     = tx_valid & ready_reg;
  assign in_pkt     = (state_reg == mts_pkg::MTS_IN_PKT);
  assign gap_seen   = in_pkt & ~tx_valid;
  assign corrupt    = accept & tx_beat.eop & tx_beat.error;
  assign ready_next = ctrl_reg[`MTS_CTRL_ENABLE] & lanes_stable & link_ready;

  // Frame length at end beat, preamble excluded when passed through
  assign frame_bytes = (tx_beat.sop ? 16'h0000 : bytes_reg)
                     + {10'h000, `MTS_BEAT_BYTES}
                     - {11'h000, tx_beat.empty}
                     - (ctrl_reg[`MTS_CTRL_PREAMBLE] ? `MTS_PREAMBLE_BYTES : 16'h0000);
  assign short_seen  = accept & tx_beat.eop & (frame_bytes < `MTS_MIN_FRAME);

  // Packet tracking; sop and eop in one beat leaves the tracker idle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      mts_pkg::MTS_IDLE: begin
        if (accept & tx_beat.sop & ~tx_beat.eop) begin
          state_next = mts_pkg::MTS_IN_PKT;
        end
      end
      mts_pkg::MTS_IN_PKT: begin
        if (accept & tx_beat.eop) begin
          state_next = mts_pkg::MTS_IDLE;
        end
      end
    endcase
  end

  // Error block: sync header, type, eight error characters
  wire logic [65:0] eblock_word;
  wire logic [`MTS_DATA_W-1:0] link_data;
  assign eblock_word[1:0] = `MTS_BLK_SYNC;
  assign eblock_word[9:2] = `MTS_BLK_TYPE;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_echar
      assign eblock_word[10+7*gi +: 7] = `MTS_CTL_ERR;
    end
    for (gi = 0; gi < `MTS_N_WORDS; gi++) begin : g_word
      // Every word of a corrupted end beat is overwritten
      assign link_data[64*gi +: 64] = corrupt ? {8{`MTS_DATA_ERR}}
                                              : tx_beat.data[64*gi +: 64];
    end
  endgenerate

  // Sink handshake and packet state
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= mts_pkg::MTS_IDLE;
      ready_reg <= 1'b0;
      bytes_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      ready_reg <= ready_next;
      if (accept) begin
        bytes_reg <= tx_beat.sop ? {10'h000, `MTS_BEAT_BYTES}
                                 : bytes_reg + {10'h000, `MTS_BEAT_BYTES};
      end
    end
  end

  // Beat forwarding, qualified by valid
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      link_reg       <= '0;
      link_valid_reg <= 1'b0;
      eblock_reg     <= 66'h0;
    end else begin
      link_valid_reg <= accept;
      if (accept) begin
        link_reg.data         <= link_data;
        link_reg.empty        <= tx_beat.empty;
        link_reg.sop          <= tx_beat.sop;
        link_reg.eop          <= tx_beat.eop;
        link_reg.add_preamble <= tx_beat.sop & ~ctrl_reg[`MTS_CTRL_PREAMBLE];
        link_reg.corrupt      <= corrupt;
      end
      eblock_reg <= eblock_word;
    end
  end

  // Loopback return of an errored packet
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lb_mal_reg <= 1'b0;
    end else begin
      lb_mal_reg <= corrupt & ctrl_reg[`MTS_CTRL_LOOPBACK];
    end
  end

  // APB decode
  wire logic       apb_access;
  wire logic       apb_done;
  wire logic       hit_ctrl;
  wire logic       hit_status;
  wire logic       hit_pkt;
  wire logic       hit_err;
  wire logic       hit_mal;
  wire logic       mapped;
  wire logic       wr_done;
  wire logic [31:0] rd_mux;
  wire logic       gap_clr;
  wire logic       short_clr;

  assign apb_access = psel & penable & ~pready_reg;
  assign apb_done   = psel & penable & pready_reg;
  assign hit_ctrl   = (paddr == `MTS_OFF_CTRL);
  assign hit_status = (paddr == `MTS_OFF_STATUS);
  assign hit_pkt    = (paddr == `MTS_OFF_PKT_CNT);
  assign hit_err    = (paddr == `MTS_OFF_ERR_CNT);
  assign hit_mal    = (paddr == `MTS_OFF_MAL_CNT);
  assign mapped     = hit_ctrl | hit_status | hit_pkt | hit_err | hit_mal;
  assign wr_done    = apb_done & pwrite;
  assign gap_clr    = wr_done & hit_status & pwdata[`MTS_ST_GAP_ERR];
  assign short_clr  = wr_done & hit_status & pwdata[`MTS_ST_SHORT_ERR];
  assign rd_mux     = hit_ctrl   ? {29'h0, ctrl_reg} :
                      hit_status ? {28'h0, short_err_reg, gap_err_reg, in_pkt, lanes_stable} :
                      hit_pkt    ? pkt_cnt_reg :
                      hit_err    ? err_cnt_reg :
                      hit_mal    ? mal_cnt_reg : 32'h0;

  // APB answer: one wait state, error on unmapped address
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= apb_access;
      pslverr_reg <= apb_access & ~mapped;
      if (apb_access & ~pwrite) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  // Control register and sticky protocol flags; set beats clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg      <= `MTS_CTRL_RESET;
      gap_err_reg   <= 1'b0;
      short_err_reg <= 1'b0;
    end else begin
      if (wr_done & hit_ctrl) begin
        ctrl_reg <= pwdata[2:0];
      end
      gap_err_reg   <= gap_seen | (gap_err_reg & ~gap_clr);
      short_err_reg <= short_seen | (short_err_reg & ~short_clr);
    end
  end

  // Packet counters
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pkt_cnt_reg <= '0;
      err_cnt_reg <= '0;
      mal_cnt_reg <= '0;
    end else begin
      if (accept & tx_beat.eop) begin
        pkt_cnt_reg <= pkt_cnt_reg + 1'b1;
      end
      if (corrupt) begin
        err_cnt_reg <= err_cnt_reg + 1'b1;
      end
      if (lb_mal_reg) begin
        mal_cnt_reg <= mal_cnt_reg + 1'b1;
      end
    end
  end

  // Outputs straight from flip-flops
  assign tx_ready            = ready_reg;
  assign link_beat           = link_reg;
  assign link_valid          = link_valid_reg;
  assign error_block_pattern = eblock_reg;
  assign lb_malformed        = lb_mal_reg;
  assign pready              = pready_reg;
  assign prdata              = prdata_reg;
  assign pslverr             = pslverr_reg;

endmodule : mts_tx_sink

// File: mts_chk.sv
// Port checker for the transmit client stream sink
`timescale 1ns/100ps
`include "mts_cfg.svh"
module mts_chk (
  // Clock and reset
  input wire logic                  ref_clk,
  input wire logic                  resetn,
  // Client stream
  input wire mts_pkg::mts_beat_type tx_beat,
  input wire logic                  tx_valid,
  input wire logic                  tx_ready,
  // Framing side
  input wire logic                  lanes_stable,
  input wire logic                  link_ready,
  input wire mts_pkg::mts_link_type link_beat,
  input wire logic                  link_valid,
  input wire logic [65:0]           error_block_pattern
);
  wire logic take;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Beat accepted at this edge
  assign take = tx_valid && tx_ready;
  a_take_fwd: assert property (take |=> link_valid)
    else $error("accepted beat not forwarded");
  a_no_take: assert property (!take |=> !link_valid)
    else $error("beat forwarded without handshake");
  a_ready_lanes: assert property (!lanes_stable |=> !tx_ready)
    else $error("ready high while lanes unstable");
  a_ready_link: assert property ($fell(link_ready) |=> !tx_ready)
    else $error("ready high while link stalled");
  a_err_block: assert property ($past(resetn) |->
    error_block_pattern == {{8{`MTS_CTL_ERR}}, `MTS_BLK_TYPE, `MTS_BLK_SYNC})
    else $error("error block pattern wrong");
  a_data_fwd: assert property (take && !(tx_beat.eop && tx_beat.error) |=>
    link_beat.data == $past(tx_beat.data))
    else $error("forwarded data differs");
  a_err_corrupt: assert property (take && tx_beat.eop && tx_beat.error |=>
    link_beat.corrupt && link_beat.data == {32{`MTS_DATA_ERR}})
    else $error("errored end beat not corrupted");
  a_frame_fwd: assert property (take |=> link_beat.sop == $past(tx_beat.sop) &&
    link_beat.eop == $past(tx_beat.eop) && link_beat.empty == $past(tx_beat.empty))
    else $error("framing fields not forwarded");
endmodule : mts_chk
bind mts_tx_sink mts_chk u_chk (.ref_clk(ref_clk), .resetn(resetn), .tx_beat(tx_beat),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .lanes_stable(lanes_stable), .link_ready(link_ready),
  .link_beat(link_beat), .link_valid(link_valid), .error_block_pattern(error_block_pattern));

// File: mts_src.sv
// Client packet source model for the stream sink bench
`timescale 1ns/100ps
module mts_src (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  // Command from the bench
  input  wire logic             go,
  input  wire logic [3:0]       nbeats,
  input  wire logic             err,
  output logic                  busy,
  // Client stream
  input  wire logic             tx_ready,
  input  wire logic             lanes_stable,
  output mts_pkg::mts_beat_type tx_beat,
  output logic                  tx_valid
);
  logic [3:0] left_reg;
  logic [3:0] left_next;
  logic       adv;
  // Next beat bookkeeping
  assign left_next = (left_reg != 4'h0 ? left_reg : nbeats) - 4'h1;
  assign adv       = left_reg != 4'h0 || (go && lanes_stable);
  assign busy      = tx_valid || left_reg != 4'h0;
  // Beat launch; a stalled beat stays put
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      left_reg <= 4'h0;
      tx_valid <= 1'b0;
      tx_beat  <= '0;
    end else if (!tx_valid || tx_ready) begin
      tx_valid <= adv;
      if (adv) begin
        left_reg      <= left_next;
        tx_beat.data  <= {32{4'hC, left_next}};
        tx_beat.sop   <= left_reg == 4'h0;
        tx_beat.eop   <= left_next == 4'h0;
        tx_beat.empty <= left_next == 4'h0 ? 5'h10 : 5'h00;
        tx_beat.error <= err && left_next == 4'h0;
      end else begin
        tx_beat.data <= ~tx_beat.data;
      end
    end
  end
endmodule : mts_src

// File: tb_top.sv
// Self-checking bench for the transmit client stream sink
`timescale 1ns/100ps
module tb_top;
  logic                  ref_clk = 1'b0;
  logic                  resetn = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0;
  logic                  pready, pslverr, tx_valid, tx_ready, link_valid, lb_malformed, busy;
  logic [31:0]           prdata, rd;
  logic                  lanes_stable = 1'b0;
  logic                  link_ready = 1'b1;
  logic                  go = 1'b0;
  logic [3:0]            nbeats = 4'h1;
  logic                  err = 1'b0;
  logic                  seen_pre, seen_cor, se;
  mts_pkg::mts_beat_type tx_beat;
  mts_pkg::mts_link_type link_beat;
  logic [65:0]           error_block_pattern;
  int                    num_errors = 0;
  int                    total_checks = 0;
  int                    cycles = 0;
  int                    mal_pulses = 0;
  int                    fwd_beats = 0;
  mts_tx_sink dut (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .tx_beat, .tx_valid, .tx_ready, .lanes_stable, .link_ready, .link_beat, .link_valid,
    .error_block_pattern, .lb_malformed);
  mts_src u_src (.ref_clk, .resetn, .go, .nbeats, .err, .busy, .tx_ready, .lanes_stable, .tx_beat,
    .tx_valid);
  // Clock, watchdog and forwarded beat capture
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
    if (link_valid === 1'b1 && link_beat.sop === 1'b1) seen_pre <= link_beat.add_preamble;
    if (link_valid === 1'b1 && link_beat.eop === 1'b1) seen_cor <= link_beat.corrupt;
    if (link_valid === 1'b1) fwd_beats++;
    if (lb_malformed === 1'b1) mal_pulses++;
  end
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic send(input logic [3:0] n, input logic e);
    nbeats <= n;
    err    <= e;
    go     <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    while (busy === 1'b1) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
  endtask : send
  task automatic t_regs_and_lanes();
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl reset", rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped err", {31'h0, se}, 32'h1);
    apb(1'b1, 8'h00, 32'h1);
    repeat (4) @(posedge ref_clk);
    check("ready lanes low", {31'h0, tx_ready}, 32'h0);
    lanes_stable <= 1'b1;
    repeat (3) @(posedge ref_clk);
    apb(1'b0, 8'h04, 32'h0);
    check("status lanes", rd & 32'h1, 32'h1);
  endtask : t_regs_and_lanes
  task automatic t_stall();
    fork
      send(4'h3, 1'b0);
      begin
        repeat (1) @(posedge ref_clk);
        link_ready <= 1'b0;
        repeat (4) @(posedge ref_clk);
        link_ready <= 1'b1;
      end
    join
    check("beats forwarded", fwd_beats, 32'h3);
    apb(1'b0, 8'h08, 32'h0);
    check("pkt count", rd, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    check("no gap err", rd & 32'hC, 32'h0);
  endtask : t_stall
  task automatic t_err_loopback();
    apb(1'b1, 8'h00, 32'h5);
    send(4'h1, 1'b1);
    check("corrupt flag", {31'h0, seen_cor}, 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    check("err count", rd, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    check("malformed count", rd, 32'h1);
    check("malformed pulses", mal_pulses, 32'h1);
  endtask : t_err_loopback
  task automatic t_preamble();
    apb(1'b1, 8'h00, 32'h3);
    send(4'h2, 1'b0);
    check("pass-through", {31'h0, seen_pre}, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    send(4'h2, 1'b0);
    check("mac preamble", {31'h0, seen_pre}, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    check("pkt total", rd, 32'h4);
    check("no malformed", mal_pulses, 32'h1);
  endtask : t_preamble
  initial begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_regs_and_lanes();
    t_stall();
    t_err_loopback();
    t_preamble();
    conclude();
  end
endmodule : tb_top
